/* File: src/srap_core.sv */
// spi slave giving register and fifo access to an external controller
`timescale 1ns/10ps
module srap_core (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic shutdown,
	input wire logic sck,
	input wire logic csn,
	input wire logic mosi,
	output logic miso_o,
	output logic miso_oe,
	output srap_pkg::srap_wr_t reg_wr,
	output logic reg_wr_valid,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic rx_ready
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	// reference domain
	logic rst_link_q;
	logic [7:0] regs_q [srap_pkg::NUM_REGS];
	logic [7:0] rx_head_q;
	logic rx_head_vld_q;
	logic wr_seen_q;
	logic pop_seen_q;
	logic pend_q;
	srap_pkg::srap_wr_t pend_word_q;
	srap_pkg::srap_wr_t reg_wr_q;
	logic reg_wr_valid_q;
	logic [2:0] sync_in;
	logic [2:0] sync_out;
	logic wr_tgl_s;
	logic pop_tgl_s;
	logic shut_s;
	logic wr_evt;
	logic pop_evt;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic [srap_pkg::WR_W-1:0] buf_out_bits;
	srap_pkg::srap_wr_t buf_out;
	logic out_is_fifo;

	// link domain, rising edge
	logic [2:0] bit_cnt_q;
	logic [6:0] shift_q;
	srap_pkg::srap_phase_t phase_q;
	srap_pkg::srap_cmd_t cmd_q;
	logic [5:0] addr_q;
	srap_pkg::srap_wr_t wr_word_q;
	logic wr_tgl_q;
	logic [7:0] in_byte;
	logic byte_end;

	// link domain, falling edge; the pop toggle is on the rising edge
	logic [2:0] idx_q;
	logic first_q;
	logic fifo_ld_q;
	logic [7:0] tx_byte_q;
	logic pop_tgl_q;
	logic rd_sel;
	logic from_fifo;
	logic [7:0] next_byte;

	// ------------------------------------------------------------
	// serial output pin
	// ------------------------------------------------------------
	// drive only while selected, float otherwise
	assign miso_oe = ~csn;

	// command byte shows register zero, later bytes the loaded byte
	always_comb begin
		if (first_q) begin
			miso_o = regs_q[srap_pkg::STATUS_ADDR][~idx_q];
		end else begin
			miso_o = tx_byte_q[~idx_q];
		end
	end

	// ------------------------------------------------------------
	// link domain: receive on rising edge
	// ------------------------------------------------------------
	// completed byte, msb first, includes the bit on the pin now
	assign in_byte = {shift_q, mosi};
	assign byte_end = (bit_cnt_q == srap_pkg::BIT_LAST);

	// bit counter; select high clears every frame register except the write word and the write and pop toggles
	always_ff @(posedge sck or posedge csn) begin
		if (csn) begin
			bit_cnt_q <= srap_pkg::BIT_FIRST;
		end else begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
		end
	end

	// input shift register sampled on the rising edge
	always_ff @(posedge sck or posedge csn) begin
		if (csn) begin
			shift_q <= 7'h00;
		end else begin
			shift_q <= in_byte[6:0];
		end
	end

	// transaction phase: command, data bytes, then ignore
	always_ff @(posedge sck or posedge csn) begin
		if (csn) begin
			phase_q <= srap_pkg::PH_CMD;
		end else if (byte_end) begin
			unique case (phase_q)
				srap_pkg::PH_CMD: begin
					phase_q <= srap_pkg::PH_DATA;
				end
				srap_pkg::PH_DATA: begin
					if (!cmd_q.burst) begin
						phase_q <= srap_pkg::PH_DONE;
					end
				end
				srap_pkg::PH_DONE: begin
					phase_q <= srap_pkg::PH_DONE;
				end
			endcase
		end
	end

	// command fields held for the rest of the frame
	always_ff @(posedge sck or posedge csn) begin
		if (csn) begin
			cmd_q <= '0;
		end else if (phase_q == srap_pkg::PH_CMD && byte_end) begin
			cmd_q <= srap_pkg::srap_cmd_t'(in_byte);
		end
	end

	// address pointer: loaded from command, stepped in burst
	always_ff @(posedge sck or posedge csn) begin
		if (csn) begin
			addr_q <= srap_pkg::STATUS_ADDR;
		end else if (phase_q == srap_pkg::PH_CMD && byte_end) begin
			addr_q <= in_byte[5:0];
		end else if (phase_q == srap_pkg::PH_DATA && byte_end
			&& cmd_q.burst && addr_q != srap_pkg::FIFO_ADDR) begin
			addr_q <= addr_q + 6'h01;
		end
	end

	// write word capture; the toggle survives select so no event is
	// invented when a frame ends
	always_ff @(posedge sck or posedge rst_link_q) begin
		if (rst_link_q) begin
			wr_word_q <= '0;
			wr_tgl_q <= 1'b0;
		end else if (!csn && phase_q == srap_pkg::PH_DATA && byte_end
			&& cmd_q.write) begin
			wr_word_q <= '{addr: addr_q, data: in_byte};
			wr_tgl_q <= ~wr_tgl_q;
		end
	end

	// ------------------------------------------------------------
	// link domain: transmit on falling edge, pop toggle on rising edge
	// ------------------------------------------------------------
	// reads answer only in data phase; writes and spent frames send 0
	assign rd_sel = (phase_q == srap_pkg::PH_DATA) && !cmd_q.write;
	assign from_fifo = rd_sel && (addr_q == srap_pkg::FIFO_ADDR);

	// register contents are quasi-static here; a word written in the
	// same few cycles may read as old or new value
	always_comb begin
		if (!rd_sel) begin
			next_byte = srap_pkg::IDLE_BYTE;
		end else if (from_fifo) begin
			next_byte = rx_head_vld_q ? rx_head_q : srap_pkg::IDLE_BYTE;
		end else begin
			next_byte = regs_q[addr_q];
		end
	end

	// bit index and byte load on the falling edge
	always_ff @(negedge sck or posedge csn) begin
		if (csn) begin
			idx_q <= srap_pkg::BIT_FIRST;
			first_q <= 1'b1;
			tx_byte_q <= srap_pkg::IDLE_BYTE;
			fifo_ld_q <= 1'b0;
		end else begin
			idx_q <= idx_q + 3'h1;
			if (idx_q == srap_pkg::BIT_LAST) begin
				first_q <= 1'b0;
				tx_byte_q <= next_byte;
				fifo_ld_q <= from_fifo && rx_head_vld_q;
			end
		end
	end

	// one fifo pop per byte read at the fifo address; taken when the
	// byte starts to leave, so the preload after a frame's last byte
	// never costs a fifo entry
	always_ff @(posedge sck or posedge rst_link_q) begin
		if (rst_link_q) begin
			pop_tgl_q <= 1'b0;
		end else if (!csn && bit_cnt_q == srap_pkg::BIT_FIRST
			&& fifo_ld_q) begin
			pop_tgl_q <= ~pop_tgl_q;
		end
	end

	// ------------------------------------------------------------
	// reference domain: crossings
	// ------------------------------------------------------------
	// registered reset for the link toggles, asserted on a reference clock edge
	always_ff @(posedge ref_clk) begin
		rst_link_q <= ~nrst;
	end

	assign sync_in = {wr_tgl_q, pop_tgl_q, shutdown};

	srap_sync #(
		.W(3)
	) u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.clk_en(clk_en),
		.d(sync_in),
		.q(sync_out)
	);

	assign wr_tgl_s = sync_out[2];
	assign pop_tgl_s = sync_out[1];
	assign shut_s = sync_out[0];
	assign wr_evt = (wr_tgl_s != wr_seen_q);
	assign pop_evt = (pop_tgl_s != pop_seen_q);

	// edge detectors on the synchronised toggles
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wr_seen_q <= 1'b0;
			pop_seen_q <= 1'b0;
		end else if (clk_en) begin
			wr_seen_q <= wr_tgl_s;
			pop_seen_q <= pop_tgl_s;
		end
	end

	// pending write word; a new arrival wins over the drain
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pend_q <= 1'b0;
			pend_word_q <= '0;
		end else if (clk_en) begin
			if (wr_evt) begin
				pend_q <= 1'b1;
				pend_word_q <= wr_word_q;
			end else if (buf_in_ready) begin
				pend_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// reference domain: write buffer and its drain
	// ------------------------------------------------------------
	srap_buf #(
		.W(srap_pkg::WR_W)
	) u_buf (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.clk_en(clk_en),
		.in_valid(pend_q),
		.in_ready(buf_in_ready),
		.in_data(pend_word_q),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_out_bits)
	);

	// fifo words wait for the transmit side, register words never do
	assign buf_out = srap_pkg::srap_wr_t'(buf_out_bits);
	assign out_is_fifo = (buf_out.addr == srap_pkg::FIFO_ADDR);
	assign buf_out_ready = out_is_fifo ? tx_ready : 1'b1;
	assign tx_data = buf_out.data;
	assign tx_valid = buf_out_valid && out_is_fifo;

	// register array; defaults on reset and while shut down
	always_ff @(posedge ref_clk) begin
		if (!nrst || shut_s) begin
			for (int i = 0; i < srap_pkg::NUM_REGS; i++) begin
				regs_q[i] <= srap_pkg::REG_RESET;
			end
		end else if (clk_en && buf_out_valid && !out_is_fifo) begin
			regs_q[buf_out.addr] <= buf_out.data;
		end
	end

	// write notice to the rest of the device
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			reg_wr_q <= '0;
			reg_wr_valid_q <= 1'b0;
		end else if (clk_en) begin
			reg_wr_valid_q <= buf_out_valid && !out_is_fifo;
			if (buf_out_valid && !out_is_fifo) begin
				reg_wr_q <= buf_out;
			end
		end
	end

	assign reg_wr = reg_wr_q;
	assign reg_wr_valid = reg_wr_valid_q;

	// ------------------------------------------------------------
	// reference domain: receive fifo head
	// ------------------------------------------------------------
	// prefetched byte offered to the link; refilled after each pop
	assign rx_ready = ~rx_head_vld_q;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rx_head_vld_q <= 1'b0;
			rx_head_q <= srap_pkg::IDLE_BYTE;
		end else if (clk_en) begin
			if (pop_evt) begin
				rx_head_vld_q <= 1'b0;
			end else if (rx_valid && !rx_head_vld_q) begin
				rx_head_vld_q <= 1'b1;
				rx_head_q <= rx_data;
			end
		end
	end

endmodule : srap_core

/* File: src/srap_pkg.sv */
// shared constants and types for the spi register access port
package srap_pkg;

	// ------------------------------------------------------------
	// widths and addresses
	// ------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int NUM_REGS = 64;
	localparam logic [5:0] STATUS_ADDR = 6'h00;
	localparam logic [5:0] FIFO_ADDR = 6'h3f;

	// ------------------------------------------------------------
	// values after reset and fixed bytes
	// ------------------------------------------------------------
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] IDLE_BYTE = 8'h00;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int WR_W = ADDR_W + DATA_W;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic burst;
		logic write;
		logic [5:0] addr;
	} srap_cmd_t;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] data;
	} srap_wr_t;

	typedef enum logic [2:0] {
		PH_CMD = 3'b001,
		PH_DATA = 3'b010,
		PH_DONE = 3'b100
	} srap_phase_t;

endpackage : srap_pkg

/* File: src/srap_sync.sv */
// two-stage synchroniser for levels entering the reference clock domain
`timescale 1ns/10ps
module srap_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			meta_q <= '0;
			q <= '0;
		end else if (clk_en) begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule : srap_sync

/* File: src/srap_buf.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module srap_buf #(
	parameter int W = 14
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	logic [W-1:0] mem_q [2];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage, written only on an accepted push
	always_ff @(posedge ref_clk) begin
		if (clk_en && push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'h0;
		end else if (clk_en) begin
			if (push) begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			if (push && !pop) begin
				count_q <= count_q + 2'h1;
			end else if (pop && !push) begin
				count_q <= count_q - 2'h1;
			end
		end
	end

endmodule : srap_buf

/* File: tb/srap_asserts.sv */
// concurrent checks on the spi register access port
`timescale 1ns/10ps
module srap_asserts (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic sck,
	input wire logic csn,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire srap_pkg::srap_wr_t reg_wr,
	input wire logic reg_wr_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic rx_ready
);
	logic [4:0] n_q;
	logic [7:0] c_q;
	// rise count and command byte, cleared by select
	always_ff @(posedge sck or posedge csn) begin
		if (csn) begin
			n_q <= 5'h00;
			c_q <= 8'h00;
		end else begin
			n_q <= (n_q == 5'h10) ? n_q : n_q + 5'h01;
			c_q <= (n_q < 5'h08) ? {c_q[6:0], mosi} : c_q;
		end
	end
	oe_follow_a: assert property (@(posedge ref_clk) miso_oe == !csn)
		else $error("enable differs from select");
	launch_fall_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		!csn && $past(!csn) && $changed(miso_o) |-> !sck)
		else $error("output moved while clock high");
	wr_zero_a: assert property (@(posedge sck) disable iff (csn)
		n_q[4:3] == 2'b01 && c_q[7:6] == 2'b01 |-> !miso_o)
		else $error("write answer not zero");
	single_tail_a: assert property (@(posedge sck) disable iff (csn)
		n_q[4] && !c_q[7] |-> !miso_o)
		else $error("single access answered past second byte");
	wr_pulse_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		reg_wr_valid |=> !reg_wr_valid)
		else $error("write strobe longer than a cycle");
	wr_no_fifo_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		reg_wr_valid |-> reg_wr.addr != srap_pkg::FIFO_ADDR)
		else $error("fifo byte sent as register write");
	tx_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("stalled byte dropped or changed");
	rx_take_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		rx_valid && rx_ready |=> !rx_ready)
		else $error("fetched byte not held");
	reset_idle_a: assert property (@(posedge ref_clk)
		!nrst |=> !reg_wr_valid && !tx_valid)
		else $error("outputs busy after reset");
	cover property (@(posedge ref_clk) reg_wr_valid);
	cover property (@(posedge ref_clk) tx_valid && tx_ready);
	cover property (@(posedge ref_clk) rx_valid && rx_ready);
endmodule : srap_asserts

bind srap_core srap_asserts u_chk (.ref_clk, .nrst, .sck, .csn, .mosi,
	.miso_o, .miso_oe, .reg_wr, .reg_wr_valid, .tx_data, .tx_valid,
	.tx_ready, .rx_valid, .rx_ready);

/* File: tb/srap_host.sv */
// spi master model standing in for the external controller
`timescale 1ns/10ps
module srap_host (
	output logic sck,
	output logic csn,
	output logic mosi,
	input wire logic miso
);
	// idle: deselected, clock low; select rises from unknown a moment
	// later so every frame flop is sure to see its clear
	initial begin
		sck = 1'b0;
		mosi = 1'b0;
		#1 csn = 1'b1;
	end
	// select the device and wait; xfer puts the first bit on the line
	task automatic open_frame();
		#13 csn = 1'b0;
		#80;
	endtask : open_frame
	// one byte each way, msb first, launch on fall, sample on rise
	task automatic xfer(input logic [7:0] o, output logic [7:0] i);
		for (int k = 7; k >= 0; k--) begin
			mosi = o[k];
			#80 sck = 1'b1;
			i[k] = miso;
			#80 sck = 1'b0;
		end
	endtask : xfer
	// deselect, spoil the data line and let the device settle
	task automatic close_frame();
		#80 csn = 1'b1;
		mosi = ~mosi;
		#400;
	endtask : close_frame
endmodule : srap_host

/* File: tb/tb_top.sv */
// self-checking bench for the spi register access port
`timescale 1ns/10ps
module tb_top;
	logic ref_clk, nrst, shutdown, tx_ready, sck, csn, mosi, miso_o, miso_oe;
	logic reg_wr_valid, tx_valid, rx_valid, rx_ready;
	logic [7:0] tx_data, rx_data, m[4], bo[$], bi[$], txq[$];
	logic [7:0] sh[64] = '{default: 8'h00};
	srap_pkg::srap_wr_t reg_wr;
	srap_pkg::srap_wr_t wq[$];
	int n_fail = 0, num_checks = 0, cyc = 0, ri = 0, rn = 0;
	wire miso = miso_oe ? miso_o : 1'bz;
	assign rx_valid = ri < rn;
	assign rx_data = m[ri];

	srap_core DUT (.ref_clk, .nrst, .clk_en(1'b1), .shutdown, .sck, .csn,
		.mosi, .miso_o, .miso_oe, .reg_wr, .reg_wr_valid, .tx_data, .tx_valid,
		.tx_ready, .rx_data, .rx_valid, .rx_ready);
	srap_host host (.sck, .csn, .mosi, .miso);

	// reference clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// fifo stubs, write log and hang limit
	always @(posedge ref_clk) begin
		tx_ready <= 1'($urandom);
		if (tx_valid && tx_ready) txq.push_back(tx_data);
		if (reg_wr_valid) wq.push_back(reg_wr);
		if (!nrst) ri <= 0;
		else if (rx_valid && rx_ready) ri <= ri + 1;
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			results();
		end
	end

	function automatic logic [7:0] cmd(input logic b, w, input logic [5:0] a);
		return {b, w, a};
	endfunction : cmd

	function automatic logic [5:0] nxt(input logic [5:0] a);
		return (a == 6'h3f) ? a : a + 6'h01;
	endfunction : nxt

	task automatic chk(input logic [7:0] g, e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected byte at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk

	task automatic chkw(input srap_pkg::srap_wr_t e);
		num_checks++;
		if (wq.size() == 0 || wq.pop_front() !== e) begin
			n_fail++;
			$display("unexpected write at %0t: want %h", $time, e);
		end
	endtask : chkw

	// one frame: command, then the queued bytes
	task automatic run(input logic [7:0] c);
		logic [7:0] v;
		host.open_frame();
		host.xfer(c, v);
		bi = {v};
		foreach (bo[k]) begin
			host.xfer(bo[k], v);
			bi.push_back(v);
		end
		host.close_frame();
	endtask : run

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	// main sequence
	initial begin
		logic [5:0] a;
		logic [7:0] d;
		logic [7:0] te[$];
		int j;
		nrst = 1'b0;
		shutdown = 1'b0;
		void'($urandom(6999));
		foreach (m[k]) m[k] = (k < 3) ? 8'($urandom) : 8'h00;
		rn = 3;
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		// single write with a stray third byte, then read back
		for (int k = 0; k < 4; k++) begin
			a = (k == 0) ? 6'h00 : 6'($urandom_range(1, 62));
			d = 8'($urandom);
			bo = {d, 8'($urandom)};
			run(cmd(1'b0, 1'b1, a));
			chk(bi[0], sh[0]);
			chk(bi[1], 8'h00);
			chk(bi[2], 8'h00);
			chkw({a, d});
			sh[a] = d;
			bo = {8'($urandom)};
			run(cmd(1'b0, 1'b0, a));
			chk(bi[1], sh[a]);
		end
		// burst write across the top registers into the transmit fifo
		bo = {};
		repeat (4) bo.push_back(8'($urandom));
		run(cmd(1'b1, 1'b1, 6'h3d));
		a = 6'h3d;
		foreach (bo[k]) begin
			if (a == 6'h3f) begin
				te.push_back(bo[k]);
			end else begin
				chkw({a, bo[k]});
				sh[a] = bo[k];
			end
			a = nxt(a);
		end
		j = 0;
		while (txq.size() < te.size() && j < 100) begin
			@(posedge ref_clk);
			j++;
		end
		chk(8'(txq.size()), 8'(te.size()));
		foreach (te[k]) chk(txq[k], te[k]);
		// burst read held at the fifo address, one byte beyond the fifo running empty
		bo = {};
		repeat (5) bo.push_back(8'($urandom));
		run(cmd(1'b1, 1'b0, 6'h3e));
		a = 6'h3e;
		j = 0;
		foreach (bo[k]) begin
			chk(bi[k + 1], (a == 6'h3f) ? m[j] : sh[a]);
			if (a == 6'h3f) j++;
			a = nxt(a);
		end
		// shutdown clears what was written
		@(posedge ref_clk);
		shutdown <= 1'b1;
		repeat (8) @(posedge ref_clk);
		shutdown <= 1'b0;
		repeat (8) @(posedge ref_clk);
		run(cmd(1'b0, 1'b0, 6'h3e));
		chk(bi[1], 8'h00);
		results();
	end
endmodule : tb_top
